/* File: src/pulse_accumulation_chop_math.sv */
// Purpose: Register file and two slot accumulators for pulse chop math
// Assumes: Pulse results arrive from logic on the same clock
// Notes: Reads answer one cycle after reg_rd with reg_rvalid
module pulse_accumulation_chop_math
  import pulse_math_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire pulse_math_pkg::addr_t reg_addr, // Register address
  input wire pulse_math_pkg::word_t reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output pulse_math_pkg::word_t reg_rdata, // Read data
  output logic reg_rvalid, // Read data valid pulse
  input wire logic pulse_valid, // One ADC pulse result present
  input wire logic pulse_slot, // 0 slot A, 1 slot B
  input wire logic [pulse_math_pkg::ADC_W-1:0] pulse_data, // ADC pulse result
  output logic integ_reversed_a, // Slot A next pulse uses reversed sequence
  output logic integ_reversed_b, // Slot B next pulse uses reversed sequence
  output logic bias_enable, // Photodiode reverse bias applied
  output logic [pulse_math_pkg::BIAS_W-1:0] bias_level_a, // Slot A bias level
  output logic [pulse_math_pkg::BIAS_W-1:0] bias_level_b, // Slot B bias level
  output pulse_math_pkg::word_t sample_freq, // Sample frequency code for timing
  output logic sample_valid_a, // Slot A output sample pulse
  output logic [pulse_math_pkg::SAMPLE_ACC_W-1:0] sample_data_a, // Slot A output sample
  output logic sample_valid_b, // Slot B output sample pulse
  output logic [pulse_math_pkg::SAMPLE_ACC_W-1:0] sample_data_b // Slot B output sample
);
  typedef struct packed {
    word_t sample_freq;
    word_t sample_avg;
    logic [SLOTS-1:0][DATA_W-1:0] pol;
    logic [SLOTS-1:0][OFS_CHANNELS-1:0][DATA_W-1:0] ofs;
    logic [SLOTS-1:0][DATA_W-1:0] timing;
    word_t cathode;
    word_t math;
    logic [SLOTS-1:0][SAMPLE_ACC_W-1:0] last_out;
    word_t rdata;
    logic rvalid;
  } regs_t;

  regs_t st;
  regs_t next_st;
  logic [1:0] ofs_idx_a;
  logic [1:0] ofs_idx_b;
  logic in_ofs_a;
  logic in_ofs_b;
  logic [SLOTS-1:0] slot_valid;
  logic [SLOTS-1:0][SAMPLE_ACC_W-1:0] slot_data;
  logic [SLOTS-1:0] slot_rev;

  ////////////////////////////////////////////////////////////////////////////
  // Offset register windows
  assign in_ofs_a = (reg_addr >= ADDR_OFS_A0) && (reg_addr < ADDR_OFS_A0 + 8'(OFS_CHANNELS));
  assign in_ofs_b = (reg_addr >= ADDR_OFS_B0) && (reg_addr < ADDR_OFS_B0 + 8'(OFS_CHANNELS));
  assign ofs_idx_a = 2'(reg_addr - ADDR_OFS_A0);
  assign ofs_idx_b = 2'(reg_addr - ADDR_OFS_B0);

  always_comb
  begin
    next_st = st;
    next_st.rvalid = reg_rd;
    if (reg_wr)
    begin
      if (in_ofs_a)
        next_st.ofs[SLOT_A][ofs_idx_a] = reg_wdata;
      else if (in_ofs_b)
        next_st.ofs[SLOT_B][ofs_idx_b] = reg_wdata;
      else
      begin
        unique case (reg_addr)
          ADDR_SAMPLE_FREQ: next_st.sample_freq = reg_wdata;
          ADDR_SAMPLE_AVG: next_st.sample_avg = reg_wdata;
          ADDR_POL_A: next_st.pol[SLOT_A] = reg_wdata;
          ADDR_POL_B: next_st.pol[SLOT_B] = reg_wdata;
          ADDR_TIMING_A: next_st.timing[SLOT_A] = reg_wdata;
          ADDR_TIMING_B: next_st.timing[SLOT_B] = reg_wdata;
          ADDR_CATHODE: next_st.cathode = reg_wdata;
          ADDR_MATH: next_st.math = reg_wdata;
          default: next_st.math = st.math;
        endcase
      end
    end
    if (slot_valid[SLOT_A])
      next_st.last_out[SLOT_A] = slot_data[SLOT_A];
    if (slot_valid[SLOT_B])
      next_st.last_out[SLOT_B] = slot_data[SLOT_B];
    if (reg_rd)
    begin
      if (in_ofs_a)
        next_st.rdata = st.ofs[SLOT_A][ofs_idx_a];
      else if (in_ofs_b)
        next_st.rdata = st.ofs[SLOT_B][ofs_idx_b];
      else
      begin
        unique case (reg_addr)
          ADDR_SAMPLE_FREQ: next_st.rdata = st.sample_freq;
          ADDR_SAMPLE_AVG: next_st.rdata = st.sample_avg;
          ADDR_POL_A: next_st.rdata = st.pol[SLOT_A];
          ADDR_POL_B: next_st.rdata = st.pol[SLOT_B];
          ADDR_TIMING_A: next_st.rdata = st.timing[SLOT_A];
          ADDR_TIMING_B: next_st.rdata = st.timing[SLOT_B];
          ADDR_CATHODE: next_st.rdata = st.cathode;
          ADDR_MATH: next_st.rdata = st.math;
          ADDR_OUT_A_LO: next_st.rdata = st.last_out[SLOT_A][DATA_W-1:0];
          ADDR_OUT_A_HI: next_st.rdata = st.last_out[SLOT_A][SAMPLE_ACC_W-1:DATA_W];
          ADDR_OUT_B_LO: next_st.rdata = st.last_out[SLOT_B][DATA_W-1:0];
          ADDR_OUT_B_HI: next_st.rdata = st.last_out[SLOT_B][SAMPLE_ACC_W-1:DATA_W];
          default: next_st.rdata = REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus answers
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign sample_freq = st.sample_freq;

  ////////////////////////////////////////////////////////////////////////////
  // Photodiode reverse bias
  assign bias_enable = st.cathode[BIAS_EN_BIT];
  assign bias_level_a = bias_enable ? st.cathode[BIAS_A_LSB +: BIAS_W] : '0;
  assign bias_level_b = bias_enable ? st.cathode[BIAS_B_LSB +: BIAS_W] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Slot accumulators
  for (genvar s = 0; s < SLOTS; s++)
  begin : g_slot
    slot_link_if link ();
    assign link.pulse_count = st.timing[s][PCOUNT_LSB +: PCOUNT_W];
    assign link.avg_log2 = (s == SLOT_A) ? st.sample_avg[AVG_A_LSB +: AVG_W] :
                           st.sample_avg[AVG_B_LSB +: AVG_W];
    assign link.pattern = st.pol[s][POL_W-1:0];
    assign link.math12 = (s == SLOT_A) ? st.math[MATH_A12_LSB +: MATH_W] : st.math[MATH_B12_LSB +: MATH_W];
    assign link.math34 = (s == SLOT_A) ? st.math[MATH_A34_LSB +: MATH_W] : st.math[MATH_B34_LSB +: MATH_W];
    assign link.offset = st.ofs[s][0];
    assign link.pulse_valid = pulse_valid && (pulse_slot == 1'(s));
    assign link.pulse_data = pulse_data;
    assign slot_valid[s] = link.out_valid;
    assign slot_data[s] = link.out_data;
    assign slot_rev[s] = link.reversed;

    slot_accumulator u_acc (
      .clk(clk),
      .srst(srst),
      .link(link)
    );
  end

  assign integ_reversed_a = slot_rev[SLOT_A];
  assign integ_reversed_b = slot_rev[SLOT_B];
  assign sample_valid_a = slot_valid[SLOT_A];
  assign sample_valid_b = slot_valid[SLOT_B];
  assign sample_data_a = slot_data[SLOT_A];
  assign sample_data_b = slot_data[SLOT_B];
endmodule

/* File: src/pulse_math_pkg.sv */
// Purpose: Constants for the pulse combination and chop math datapath
// Assumes: 16-bit registers at 8-bit addresses, one ADC result per pulse
// Notes: Field positions are bit offsets inside their registers
package pulse_math_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int ADC_W = 14;
  localparam int PULSE_ACC_W = 24;
  localparam int SAMPLE_ACC_W = 32;
  localparam int SLOTS = 2;
  localparam int SLOT_A = 0;
  localparam int SLOT_B = 1;
  localparam int OFS_CHANNELS = 4;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  ////////////////////////////////////////////////////////////////////////////
  localparam addr_t ADDR_SAMPLE_FREQ = 8'h12;
  localparam addr_t ADDR_SAMPLE_AVG = 8'h15;
  localparam addr_t ADDR_POL_A = 8'h17;
  localparam addr_t ADDR_OFS_A0 = 8'h18;
  localparam addr_t ADDR_POL_B = 8'h1D;
  localparam addr_t ADDR_OFS_B0 = 8'h1E;
  localparam addr_t ADDR_TIMING_A = 8'h31;
  localparam addr_t ADDR_TIMING_B = 8'h36;
  localparam addr_t ADDR_CATHODE = 8'h54;
  localparam addr_t ADDR_MATH = 8'h58;
  localparam addr_t ADDR_OUT_A_LO = 8'h60;
  localparam addr_t ADDR_OUT_A_HI = 8'h61;
  localparam addr_t ADDR_OUT_B_LO = 8'h62;
  localparam addr_t ADDR_OUT_B_HI = 8'h63;
  localparam word_t REG_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  localparam int PCOUNT_LSB = 8;
  localparam int PCOUNT_W = 8;
  localparam int AVG_A_LSB = 4;
  localparam int AVG_B_LSB = 8;
  localparam int AVG_W = 3;
  localparam int POL_W = 4;
  localparam int BIAS_EN_BIT = 7;
  localparam int BIAS_A_LSB = 8;
  localparam int BIAS_B_LSB = 10;
  localparam int BIAS_W = 2;
  localparam int MATH_A12_LSB = 1;
  localparam int MATH_A34_LSB = 8;
  localparam int MATH_B12_LSB = 5;
  localparam int MATH_B34_LSB = 10;
  localparam int MATH_W = 2;
  localparam int MATH_SUB_FIRST_BIT = 1;
  localparam int MATH_SUB_SECOND_BIT = 0;
  localparam int SAMP_IDX_W = 8;
endpackage

/* File: src/slot_link_if.sv */
// Purpose: Carries one slot's settings, pulse stream and result
// Assumes: Single clock domain
// Notes: ctrl drives settings and pulses, slot returns results
interface slot_link_if;
  import pulse_math_pkg::*;
  logic [PCOUNT_W-1:0] pulse_count;
  logic [AVG_W-1:0] avg_log2;
  logic [POL_W-1:0] pattern;
  logic [MATH_W-1:0] math12;
  logic [MATH_W-1:0] math34;
  logic [DATA_W-1:0] offset;
  logic pulse_valid;
  logic [ADC_W-1:0] pulse_data;
  logic reversed;
  logic out_valid;
  logic [SAMPLE_ACC_W-1:0] out_data;
  modport ctrl (output pulse_count, avg_log2, pattern, math12, math34, offset, pulse_valid, pulse_data,
                input reversed, out_valid, out_data);
  modport slot (input pulse_count, avg_log2, pattern, math12, math34, offset, pulse_valid, pulse_data,
                output reversed, out_valid, out_data);
endinterface

/* File: src/slot_accumulator.sv */
// Purpose: Combines pulse results into internal samples, then sums samples
// Assumes: One ADC result per pulse_valid cycle
// Notes: Pulse count of zero ignores pulses
module slot_accumulator
  import pulse_math_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  slot_link_if.slot link // Settings in, results out
);
  typedef struct packed {
    logic [PCOUNT_W-1:0] pulse_idx;
    logic signed [PULSE_ACC_W-1:0] pulse_acc;
    logic [SAMP_IDX_W-1:0] samp_idx;
    logic signed [SAMPLE_ACC_W-1:0] samp_acc;
    logic out_valid;
    logic [SAMPLE_ACC_W-1:0] out_data;
  } acc_state_t;

  acc_state_t st;
  acc_state_t next_st;
  logic [MATH_W-1:0] pair_math;
  logic subtract;
  logic signed [PULSE_ACC_W-1:0] term;
  logic signed [PULSE_ACC_W-1:0] pulse_sum;
  logic signed [SAMPLE_ACC_W-1:0] samp_sum;
  logic [SAMP_IDX_W-1:0] samp_last;

  ////////////////////////////////////////////////////////////////////////////
  // Polarity of the pulse about to be integrated
  assign link.reversed = link.pattern[st.pulse_idx[1:0]];
  assign link.out_valid = st.out_valid;
  assign link.out_data = st.out_data;

  always_comb
  begin
    next_st = st;
    next_st.out_valid = 1'b0;
    pair_math = st.pulse_idx[1] ? link.math34 : link.math12;
    subtract = st.pulse_idx[0] ? pair_math[MATH_SUB_SECOND_BIT] : pair_math[MATH_SUB_FIRST_BIT];
    term = PULSE_ACC_W'(link.pulse_data) - PULSE_ACC_W'(link.offset);
    pulse_sum = subtract ? (st.pulse_acc - term) : (st.pulse_acc + term);
    samp_sum = st.samp_acc + SAMPLE_ACC_W'(pulse_sum);
    samp_last = SAMP_IDX_W'((9'h001 << link.avg_log2) - 9'h001);
    if (link.pulse_valid && (link.pulse_count != '0))
    begin
      if (st.pulse_idx == PCOUNT_W'(link.pulse_count - 8'h01))
      begin
        next_st.pulse_idx = '0;
        next_st.pulse_acc = '0;
        if (st.samp_idx >= samp_last)
        begin
          next_st.samp_idx = '0;
          next_st.samp_acc = '0;
          next_st.out_valid = 1'b1;
          next_st.out_data = samp_sum;
        end
        else
        begin
          next_st.samp_idx = st.samp_idx + 8'h01;
          next_st.samp_acc = samp_sum;
        end
      end
      else
      begin
        next_st.pulse_idx = st.pulse_idx + 8'h01;
        next_st.pulse_acc = pulse_sum;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

/* File: testbench/pulse_math_sva.sv */
// Purpose: Port-level checks of the pulse chop math block
// Assumes: One clock, srst synchronous and active high
// Notes: Bound to every instance of the top module
module pulse_math_sva
  import pulse_math_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire pulse_math_pkg::addr_t reg_addr, // Address
  input wire pulse_math_pkg::word_t reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic reg_rvalid, // Read answer
  input wire logic pulse_valid, // Pulse present
  input wire logic pulse_slot, // Pulse slot
  input wire logic bias_enable, // Bias on
  input wire logic [pulse_math_pkg::BIAS_W-1:0] bias_level_a, // Level A
  input wire logic [pulse_math_pkg::BIAS_W-1:0] bias_level_b, // Level B
  input wire pulse_math_pkg::word_t sample_freq, // Frequency code
  input wire logic sample_valid_a, // Sample A
  input wire logic sample_valid_b // Sample B
);
  word_t wd_q;
  logic cath_wr;
  always_ff @(posedge clk) wd_q <= reg_wdata;
  assign cath_wr = reg_wr && reg_addr == ADDR_CATHODE;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  property p_rd_quiet; !reg_rd |=> !reg_rvalid; endproperty
  property p_sfreq; reg_wr && reg_addr == ADDR_SAMPLE_FREQ |=> sample_freq == wd_q; endproperty
  property p_valid_a; sample_valid_a |-> $past(pulse_valid) && !$past(pulse_slot); endproperty
  property p_valid_b; sample_valid_b |-> $past(pulse_valid) && $past(pulse_slot); endproperty
  property p_bias_en; cath_wr |=> bias_enable == wd_q[BIAS_EN_BIT]; endproperty
  property p_bias_off; !bias_enable |-> bias_level_a == 2'h0 && bias_level_b == 2'h0; endproperty
  property p_bias_lvl; cath_wr |=> wd_q[7] ? (bias_level_a == wd_q[9:8] && bias_level_b == wd_q[11:10]) : 1'b1;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
  a_sfreq: assert property (p_sfreq) else $error("frequency code not updated");
  a_valid_a: assert property (p_valid_a) else $error("slot A sample without pulse");
  a_valid_b: assert property (p_valid_b) else $error("slot B sample without pulse");
  a_bias_en: assert property (p_bias_en) else $error("bias enable wrong");
  a_bias_off: assert property (p_bias_off) else $error("bias level while disabled");
  a_bias_lvl: assert property (p_bias_lvl) else $error("bias level wrong");
  c_sample_a: cover property (sample_valid_a);
  c_sample_b: cover property (sample_valid_b);
  c_bias: cover property (bias_enable && bias_level_a == 2'h2);
endmodule

bind pulse_accumulation_chop_math pulse_math_sva u_pulse_math_sva (.clk, .srst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rvalid, .pulse_valid, .pulse_slot, .bias_enable, .bias_level_a, .bias_level_b,
  .sample_freq, .sample_valid_a, .sample_valid_b);

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the pulse chop math block
// Assumes: Offsets left at zero while chopping
// Notes: Inputs change 1 ns after the rising edge
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pulse_math_pkg::*;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pulse_valid = 0, pulse_slot = 0;
  addr_t reg_addr = '0;
  word_t reg_wdata = '0, reg_rdata, sample_freq;
  logic [ADC_W-1:0] pulse_data = '0;
  logic reg_rvalid, integ_reversed_a, integ_reversed_b, bias_enable, sample_valid_a, sample_valid_b;
  logic [BIAS_W-1:0] bias_level_a, bias_level_b;
  logic [SAMPLE_ACC_W-1:0] sample_data_a, sample_data_b;
  int err_total = 0, comparisons = 0;
  pulse_accumulation_chop_math u_pulse_accumulation_chop_math (.clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .pulse_valid, .pulse_slot, .pulse_data, .integ_reversed_a,
    .integ_reversed_b, .bias_enable, .bias_level_a, .bias_level_b, .sample_freq, .sample_valid_a,
    .sample_data_a, .sample_valid_b, .sample_data_b);
  initial
  begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task wr(input addr_t a, input word_t d);
    reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(posedge clk); #1 reg_wr = 0;
    @(posedge clk); #1;
  endtask
  task rd(input addr_t a, input word_t e);
    reg_addr = a; reg_rd = 1;
    @(posedge clk); #1 reg_rd = 0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
    @(posedge clk); #1;
  endtask
  // Valid stays up between pulses of one burst
  task pulse(input logic s, input logic [ADC_W-1:0] d, input logic last, input logic want);
    pulse_slot = s; pulse_data = d; pulse_valid = 1;
    @(posedge clk); #1;
    if (last) pulse_valid = 0;
    `CHK(s ? sample_valid_b : sample_valid_a, want)
  endtask
  task burst(input logic s, input int n, input logic [3:0] pat, input logic [3:0] neg, input int off);
    int e;
    logic [ADC_W-1:0] d;
    e = 0;
    for (int i = 0; i < n; i++)
    begin
      d = ADC_W'(500 + 61 * i * i);
      `CHK(s ? integ_reversed_b : integ_reversed_a, pat[i % 4])
      e = neg[i % 4] ? e - (int'(d) - off) : e + (int'(d) - off);
      pulse(s, d, i == n - 1, i == n - 1);
    end
    `CHK(s ? sample_data_b : sample_data_a, SAMPLE_ACC_W'(e))
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    wr(ADDR_POL_A, 16'hABCD);
    rd(ADDR_POL_A, 16'hABCD);
    rd(8'h7F, 16'h0000);
    wr(ADDR_POL_A, 16'h0000);
    $display("test regs done");
  endtask
  task t_accum;
    wr(ADDR_TIMING_A, 16'h0300);
    rd(ADDR_TIMING_A, 16'h0300);
    wr(ADDR_OFS_A0, 16'h0010);
    burst(1'b0, 3, 4'h0, 4'h0, 16);
    $display("test accum done");
  endtask
  task t_chop_a;
    wr(ADDR_TIMING_A, 16'h0800);
    wr(ADDR_OFS_A0, 16'h0000);
    wr(ADDR_POL_A, 16'h0006);
    wr(ADDR_MATH, 16'h0642);
    burst(1'b0, 8, 4'h6, 4'h6, 0);
    $display("test chop A done");
  endtask
  task t_avg_b;
    pulse(1'b1, 14'h0123, 1'b1, 1'b0);
    wr(ADDR_TIMING_B, 16'h0400);
    wr(ADDR_OFS_B0, 16'h0000);
    wr(ADDR_SAMPLE_AVG, 16'h0100);
    wr(ADDR_POL_B, 16'h0009);
    burst(1'b1, 8, 4'h9, 4'h9, 0);
    // Readback copy is taken one cycle after the sample strobe
    @(posedge clk); #1;
    rd(ADDR_OUT_B_LO, 16'hFE18);
    rd(ADDR_OUT_B_HI, 16'hFFFF);
    $display("test avg B done");
  endtask
  task t_bias;
    wr(ADDR_CATHODE, 16'h0E00);
    `CHK(bias_enable, 1'b0)
    `CHK(bias_level_a, 2'h0)
    wr(ADDR_CATHODE, 16'h0E80);
    `CHK(bias_level_a, 2'h2)
    `CHK(bias_level_b, 2'h3)
    wr(ADDR_SAMPLE_FREQ, 16'h0190);
    `CHK(sample_freq, 16'h0190)
    $display("test bias done");
  endtask
  task print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    #1 srst = 0;
    t_regs;
    t_accum;
    t_chop_a;
    t_avg_b;
    t_bias;
    print_verdict;
  end
endmodule
